//--- logic/mgw_gateway.sv
`timescale 1ns/1ps
`default_nettype none
module mgw_gateway
  import mgw_pkg::*;
#(
  parameter longint DAY_COUNT = DAY_CYCLES
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic [31:0]         auth_ip,
  input  wire logic [7:0]          panel_node_0,
  input  wire logic [7:0]          panel_node_1,
  input  wire logic [7:0]          panel_node_2,
  input  wire logic [7:0]          panel_node_3,
  input  wire logic                conn_req,
  input  wire logic [15:0]         conn_port,
  input  wire logic [31:0]         conn_ip,
  output logic                     conn_accept,
  output logic                     conn_reject,
  input  wire logic                req_valid,
  input  wire mgw_pkg::mgw_req_t   req,
  output logic                     req_ready,
  output logic                     rsp_valid,
  output mgw_pkg::mgw_rsp_t        rsp,
  input  wire logic                rsp_ready,
  input  wire logic                client_tsync,
  input  wire logic                net_tsync,
  input  wire logic [31:0]         net_time,
  output logic [31:0]              time_now,
  input  wire logic                panel_link_up,
  input  wire logic                panel_unstable,
  input  wire logic                panel_reprog,
  input  wire logic                panel_db_differs,
  input  wire logic [15:0]         panel_rd_data,
  output logic                     panel_check,
  output logic [1:0]               panel_sel,
  output logic                     panel_rd_status,
  output logic [REG_AW-1:0]        panel_rd_idx,
  output logic                     resync_busy,
  output logic                     resync_aborted
);

  //////////////////////////////////////////////////////////////////////////////

  typedef enum logic [1:0] {
    GW_IDLE = 2'b00,
    GW_EXEC = 2'b01,
    GW_RESP = 2'b11
  } mgw_gw_state_t;

  // Device type registers (input) and device status registers (holding).
  logic [15:0] type_mem [NUM_PANELS][REG_DEPTH];
  logic [15:0] stat_mem [NUM_PANELS][REG_DEPTH];

  mgw_gw_state_t state_ff;
  mgw_req_t      req_ff;
  mgw_rsp_t      rsp_ff;
  mgw_rsp_t      nxt_rsp;
  logic          wr_en;
  logic [1:0]    wr_panel;
  logic [1:0]    sel;
  logic          sel_hit;
  logic          busy;
  logic          phase_status;
  logic [REG_AW-1:0] sweep_idx;
  logic          sweep_en;
  logic [1:0]    sweep_panel_ff;
  logic [7:0]    nodes [NUM_PANELS];

  assign nodes[0] = panel_node_0;
  assign nodes[1] = panel_node_1;
  assign nodes[2] = panel_node_2;
  assign nodes[3] = panel_node_3;

  function automatic logic unit_ok(input logic [7:0] u);
    unit_ok = (u >= UNIT_MIN) && (u <= UNIT_MAX);
  endfunction

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] q);
    in_range = ({1'b0, a} + {1'b0, q}) <= 17'(REG_DEPTH);
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    sel     = 2'd0;
    sel_hit = 1'b0;
    for (int i = NUM_PANELS - 1; i >= 0; i--) begin
      if (nodes[i] == req_ff.unit_id) begin
        sel     = 2'(i);
        sel_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      conn_accept <= 1'b0;
      conn_reject <= 1'b0;
    end else begin
      conn_accept <= 1'b0;
      conn_reject <= 1'b0;
      if (conn_req) begin
        // Port 502 is fixed by design; there is nothing for software to move.
        if (conn_port == TCP_PORT && (auth_ip == IP_ANY || auth_ip == conn_ip)) begin
          conn_accept <= 1'b1;
        end else begin
          conn_reject <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      time_now <= '0;
    end else if (net_tsync) begin
      time_now <= net_time;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  assign req_ready = (state_ff == GW_IDLE);
  assign rsp_valid = (state_ff == GW_RESP);
  assign rsp       = rsp_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= GW_IDLE;
      req_ff   <= '0;
    end else begin
      unique case (state_ff)
        GW_IDLE: begin
          if (req_valid) begin
            req_ff   <= req;
            state_ff <= GW_EXEC;
          end
        end
        GW_EXEC: begin
          state_ff <= GW_RESP;
        end
        GW_RESP: begin
          if (rsp_ready) begin
            state_ff <= GW_IDLE;
          end
        end
        default: begin
          state_ff <= GW_IDLE;
        end
      endcase
    end
  end

  // One register per access keeps the answer a single word wide.
  always_comb begin
    nxt_rsp         = '0;
    nxt_rsp.unit_id = req_ff.unit_id;
    nxt_rsp.func    = req_ff.func;
    nxt_rsp.addr    = req_ff.addr;
    wr_en           = 1'b0;
    if (!unit_ok(req_ff.unit_id) || !sel_hit) begin
      nxt_rsp.func     = req_ff.func | EXC_FLAG;
      nxt_rsp.exc_code = EXC_ILL_DATA;
    end else begin
      unique case (req_ff.func)
        FC_RD_INPUT: begin
          if (req_ff.data == 16'h0000 || req_ff.data > MAX_READ_QTY) begin
            nxt_rsp.func     = req_ff.func | EXC_FLAG;
            nxt_rsp.exc_code = EXC_ILL_DATA;
          end else if (!in_range(req_ff.addr, req_ff.data)) begin
            nxt_rsp.func     = req_ff.func | EXC_FLAG;
            nxt_rsp.exc_code = EXC_ILL_ADDR;
          end else begin
            nxt_rsp.data = type_mem[sel][req_ff.addr[REG_AW-1:0]];
          end
        end
        FC_RD_HOLD: begin
          if (req_ff.data == 16'h0000 || req_ff.data > MAX_READ_QTY) begin
            nxt_rsp.func     = req_ff.func | EXC_FLAG;
            nxt_rsp.exc_code = EXC_ILL_DATA;
          end else if (!in_range(req_ff.addr, req_ff.data)) begin
            nxt_rsp.func     = req_ff.func | EXC_FLAG;
            nxt_rsp.exc_code = EXC_ILL_ADDR;
          end else begin
            nxt_rsp.data = stat_mem[sel][req_ff.addr[REG_AW-1:0]];
          end
        end
        FC_WR_SINGLE: begin
          if (!in_range(req_ff.addr, 16'h0001)) begin
            nxt_rsp.func     = req_ff.func | EXC_FLAG;
            nxt_rsp.exc_code = EXC_ILL_ADDR;
          end else begin
            nxt_rsp.data = req_ff.data;
            wr_en        = 1'b1;
          end
        end
        FC_ENCAP: begin
          if (req_ff.addr[15:8] == MEI_DEV_ID) begin
            nxt_rsp.data = {MEI_DEV_ID, DEV_ID_OBJ};
          end else begin
            nxt_rsp.func     = req_ff.func | EXC_FLAG;
            nxt_rsp.exc_code = EXC_ILL_DATA;
          end
        end
        default: begin
          nxt_rsp.func     = req_ff.func | EXC_FLAG;
          nxt_rsp.exc_code = EXC_ILL_FUNC;
        end
      endcase
    end
  end

  assign wr_panel = sel;

  always_ff @(posedge clock) begin
    if (rst) begin
      rsp_ff <= '0;
    end else if (state_ff == GW_EXEC) begin
      rsp_ff <= nxt_rsp;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Client time broadcasts are consumed without effect.
  logic unused_tsync;
  assign unused_tsync = client_tsync;

  mgw_resync #(
    .DAY_COUNT (DAY_COUNT)
  ) u_resync (
    .clock        (clock),
    .rst          (rst),
    .reprog_evt   (panel_reprog),
    .link_up      (panel_link_up),
    .unstable     (panel_unstable),
    .db_differs   (panel_db_differs),
    .check_pulse  (panel_check),
    .busy         (busy),
    .phase_status (phase_status),
    .sweep_idx    (sweep_idx),
    .sweep_en     (sweep_en),
    .aborted      (resync_aborted)
  );

  // The sweep moves to the next panel every cycle as the slot advances, so each panel sees only every fourth slot.
  always_ff @(posedge clock) begin
    if (rst) begin
      sweep_panel_ff <= 2'd0;
    end else if (!busy) begin
      sweep_panel_ff <= 2'd0;
    end else begin
      sweep_panel_ff <= sweep_panel_ff + 2'd1;
    end
  end

  assign panel_sel       = sweep_panel_ff;
  assign panel_rd_status = phase_status;
  assign panel_rd_idx    = sweep_idx;
  assign resync_busy     = busy;

  // Panel read data lags the request by one cycle, so the target is delayed.
  logic [1:0]        cap_panel_ff;
  logic [REG_AW-1:0] cap_idx_ff;
  logic              cap_stat_ff;
  logic              cap_en_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      cap_en_ff    <= 1'b0;
      cap_panel_ff <= 2'd0;
      cap_idx_ff   <= '0;
      cap_stat_ff  <= 1'b0;
    end else begin
      cap_en_ff    <= sweep_en && !panel_unstable;
      cap_panel_ff <= sweep_panel_ff;
      cap_idx_ff   <= sweep_idx;
      cap_stat_ff  <= phase_status;
    end
  end

  // Client writes win over a same-cycle refresh only for the holding array.
  always_ff @(posedge clock) begin
    if (state_ff == GW_EXEC && wr_en) begin
      stat_mem[wr_panel][req_ff.addr[REG_AW-1:0]] <= req_ff.data;
    end else if (cap_en_ff && cap_stat_ff) begin
      stat_mem[cap_panel_ff][cap_idx_ff] <= panel_rd_data;
    end
  end

  always_ff @(posedge clock) begin
    if (cap_en_ff && !cap_stat_ff) begin
      type_mem[cap_panel_ff][cap_idx_ff] <= panel_rd_data;
    end
  end

endmodule // mgw_gateway
`default_nettype wire

//--- inc/mgw_pkg.sv
// Overview of operation
// - Read-input-registers requests (function 0x04) are serviced from the input register array.
// - Read-holding-registers requests (function 0x03) are serviced from the holding register array.
// - Write-single-register requests (function 0x06) update one holding register and echo.
// - Read-device-identification (0x2B with MEI type 0x0E) is answered.
// - Invalid commands or data produce an exception response instead of a normal reply.
// - Unit identifier must be 1 to 247; other values are treated as invalid.
// - Up to four panels are bridged; the unit identifier selects the panel.
// - Connections are accepted only on fixed TCP port 502.
// - Register references follow standard ranges; input 30001-39999, holding 40001-49999.
// - Client time-sync messages are ignored; time comes only from panel network broadcasts.
// - Every 24 hours the database is compared; resync starts only on difference.
// - A panel reprogramming message starts resynchronisation.
// - Own reset, power cycle or restored panel connectivity starts resynchronisation.
// - Resync refreshes device-type registers first, then device-status registers, each panel at every fourth index only.
// - Resync is abandoned when panel or panel network becomes unstable.
// - Connections admitted only from the authorised client address, or any when 0.0.0.0.
// - Input and holding registers are sixteen bits; one of each per device address.
package mgw_pkg;

  localparam logic [7:0]  FC_RD_HOLD     = 8'h03;
  localparam logic [7:0]  FC_RD_INPUT    = 8'h04;
  localparam logic [7:0]  FC_WR_SINGLE   = 8'h06;
  localparam logic [7:0]  FC_ENCAP       = 8'h2B;
  localparam logic [7:0]  MEI_DEV_ID     = 8'h0E;
  localparam logic [7:0]  EXC_FLAG       = 8'h80;
  localparam logic [7:0]  EXC_ILL_FUNC   = 8'h01;
  localparam logic [7:0]  EXC_ILL_ADDR   = 8'h02;
  localparam logic [7:0]  EXC_ILL_DATA   = 8'h03;
  localparam logic [7:0]  UNIT_MIN       = 8'h01;
  localparam logic [7:0]  UNIT_MAX       = 8'hF7;
  localparam logic [15:0] TCP_PORT       = 16'h01F6;
  localparam logic [31:0] IP_ANY         = 32'h00000000;
  localparam int          NUM_PANELS     = 4;
  localparam int          REG_AW         = 6;
  localparam int          REG_DEPTH      = 64;
  localparam logic [15:0] MAX_READ_QTY   = 16'h007D;
  localparam logic [7:0]  DEV_ID_OBJ     = 8'h5A;  // Arbitrary identification value.
  localparam logic [15:0] REF_BASE_INPUT = 16'd30001;
  localparam logic [15:0] REF_BASE_HOLD  = 16'd40001;
  localparam int          CLK_MHZ        = 100;
  localparam longint      RESYNC_HOURS   = 24;
  localparam longint      DAY_CYCLES     = RESYNC_HOURS * 3600 * CLK_MHZ * 1000000;

  typedef struct packed {
    logic [7:0]  unit_id;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] data;
    logic [15:0] port;
    logic [31:0] client_ip;
  } mgw_req_t;

  typedef struct packed {
    logic [7:0]  unit_id;
    logic [7:0]  func;
    logic [7:0]  exc_code;
    logic [15:0] addr;
    logic [15:0] data;
  } mgw_rsp_t;

  typedef struct packed {
    logic            wr;
    logic [1:0]      panel;
    logic            is_status;
    logic [REG_AW-1:0] idx;
    logic [15:0]     data;
  } mgw_panel_wr_t;

endpackage

//--- logic/mgw_resync.sv
`timescale 1ns/1ps
`default_nettype none
module mgw_resync
  import mgw_pkg::*;
#(
  parameter longint DAY_COUNT = DAY_CYCLES
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              reprog_evt,
  input  wire logic              link_up,
  input  wire logic              unstable,
  input  wire logic              db_differs,
  output logic                   check_pulse,
  output logic                   busy,
  output logic                   phase_status,
  output logic [REG_AW-1:0]      sweep_idx,
  output logic                   sweep_en,
  output logic                   aborted
);

  typedef enum logic [1:0] {
    RS_IDLE  = 2'b00,
    RS_TYPE  = 2'b01,
    RS_STAT  = 2'b11,
    RS_CHECK = 2'b10
  } mgw_rs_state_t;

  mgw_rs_state_t   state_ff;
  logic [47:0]     day_cnt_ff;
  logic            link_ff;
  logic            pend_ff;
  logic [REG_AW-1:0] idx_ff;
  logic            abort_ff;
  logic            last;

  assign last         = (idx_ff == REG_AW'(REG_DEPTH - 1));
  assign busy         = (state_ff == RS_TYPE) || (state_ff == RS_STAT);
  assign phase_status = (state_ff == RS_STAT);
  assign sweep_idx    = idx_ff;
  assign sweep_en     = busy;
  assign aborted      = abort_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      day_cnt_ff  <= '0;
      check_pulse <= 1'b0;
    end else begin
      check_pulse <= 1'b0;
      if (day_cnt_ff == 48'(DAY_COUNT - 1)) begin
        day_cnt_ff  <= '0;
        check_pulse <= 1'b1;
      end else begin
        day_cnt_ff <= day_cnt_ff + 48'd1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      // Starting high keeps a link that is already up at reset from looking like a restore.
      link_ff <= 1'b1;
    end else begin
      link_ff <= link_up;
    end
  end

  // Triggers that arrive mid-sweep are remembered so no change is missed.
  always_ff @(posedge clock) begin
    if (rst) begin
      pend_ff <= 1'b1;
    end else if (reprog_evt || (link_up && !link_ff)) begin
      pend_ff <= 1'b1;
    end else if (state_ff == RS_CHECK && db_differs) begin
      pend_ff <= 1'b1;
    end else if (state_ff == RS_IDLE && link_up && !unstable) begin
      pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= RS_IDLE;
      idx_ff   <= '0;
      abort_ff <= 1'b0;
    end else begin
      abort_ff <= 1'b0;
      unique case (state_ff)
        RS_IDLE: begin
          idx_ff <= '0;
          if (pend_ff && link_up && !unstable) begin
            state_ff <= RS_TYPE;
          end else if (check_pulse && !reprog_evt) begin
            // A reprogramming event wins over the daily check; its sweep refreshes every fourth index of each panel anyway.
            state_ff <= RS_CHECK;
          end
        end
        RS_CHECK: begin
          state_ff <= RS_IDLE;
        end
        RS_TYPE: begin
          if (unstable || !link_up) begin
            state_ff <= RS_IDLE;
            abort_ff <= 1'b1;
          end else if (last) begin
            idx_ff   <= '0;
            state_ff <= RS_STAT;
          end else begin
            idx_ff <= idx_ff + REG_AW'(1);
          end
        end
        RS_STAT: begin
          if (unstable || !link_up) begin
            state_ff <= RS_IDLE;
            abort_ff <= 1'b1;
          end else if (last) begin
            state_ff <= RS_IDLE;
          end else begin
            idx_ff <= idx_ff + REG_AW'(1);
          end
        end
      endcase
    end
  end

endmodule // mgw_resync
`default_nettype wire

//--- dv/mgw_gateway_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mgw_gateway_sva
  import mgw_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic [31:0]       auth_ip,
  input wire logic              conn_req,
  input wire logic [15:0]       conn_port,
  input wire logic [31:0]       conn_ip,
  input wire logic              conn_accept,
  input wire logic              conn_reject,
  input wire logic              req_valid,
  input wire mgw_pkg::mgw_req_t req,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire mgw_pkg::mgw_rsp_t rsp,
  input wire logic              rsp_ready,
  input wire logic              client_tsync,
  input wire logic              net_tsync,
  input wire logic [31:0]       net_time,
  input wire logic [31:0]       time_now,
  input wire logic              panel_reprog,
  input wire logic              panel_unstable,
  input wire logic              panel_link_up,
  input wire logic              panel_rd_status,
  input wire logic              resync_busy,
  input wire logic              resync_aborted
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  logic take;
  logic bad_fn;
  assign take = req_valid && req_ready;
  assign bad_fn = !(req.func inside {FC_RD_HOLD, FC_RD_INPUT, FC_WR_SINGLE, FC_ENCAP});
  chk_rsp_timing: assert property (take |=> !req_ready ##1 rsp_valid)
    else $error("response not two cycles after take");
  chk_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
    else $error("response dropped before acceptance");
  chk_bad_unit: assert property (take && (req.unit_id < UNIT_MIN || req.unit_id > UNIT_MAX)
    |-> ##2 rsp.func[7] && rsp.exc_code == EXC_ILL_DATA) else $error("bad unit not refused");
  chk_bad_func: assert property (take && bad_fn |-> ##2 rsp.exc_code == EXC_ILL_FUNC
    && rsp.func == ($past(req.func, 2) | EXC_FLAG)) else $error("unknown function not refused");
  chk_port_only: assert property (conn_req && conn_port != TCP_PORT |=> conn_reject && !conn_accept)
    else $error("connection on wrong port admitted");
  chk_ip_admit: assert property (conn_req && conn_port == TCP_PORT &&
    (auth_ip == IP_ANY || conn_ip == auth_ip) |=> conn_accept && !conn_reject) else $error("client not admitted");
  chk_ip_block: assert property (conn_req && auth_ip != IP_ANY && conn_ip != auth_ip |=> conn_reject)
    else $error("foreign client admitted");
  chk_client_time: assert property (client_tsync && !net_tsync |=> $stable(time_now))
    else $error("client time accepted");
  chk_net_time: assert property (net_tsync |=> time_now == $past(net_time))
    else $error("network time not loaded");
  chk_reprog_go: assert property (panel_reprog && panel_link_up && !panel_unstable |-> ##[1:2] resync_busy)
    else $error("reprogramming did not start resync");
  chk_abort_seen: assert property (resync_busy && panel_unstable |-> ##[1:2] resync_aborted)
    else $error("unstable panel did not abort resync");
  chk_type_first: assert property (resync_busy && panel_rd_status |=> !resync_busy || panel_rd_status)
    else $error("type refresh after status refresh");
  cov_abort: cover property (resync_aborted);
  cov_exc: cover property (rsp_valid && rsp.func[7]);
  cov_accept: cover property (conn_accept);
endmodule // mgw_gateway_sva
bind mgw_gateway mgw_gateway_sva i_mgw_gateway_sva (.clock(clock), .rst(rst), .auth_ip(auth_ip),
  .conn_req(conn_req), .conn_port(conn_port), .conn_ip(conn_ip), .conn_accept(conn_accept),
  .conn_reject(conn_reject), .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp(rsp), .rsp_ready(rsp_ready), .client_tsync(client_tsync), .net_tsync(net_tsync), .net_time(net_time),
  .time_now(time_now), .panel_reprog(panel_reprog), .panel_unstable(panel_unstable),
  .panel_link_up(panel_link_up), .panel_rd_status(panel_rd_status), .resync_busy(resync_busy),
  .resync_aborted(resync_aborted));
`default_nettype wire

//--- dv/mgw_client.sv
`timescale 1ns/1ps
`default_nettype none
module mgw_client
  import mgw_pkg::*;
(
  input  wire logic              clock,
  output logic                   req_valid,
  output mgw_pkg::mgw_req_t      req,
  input  wire logic              req_ready,
  input  wire logic              rsp_valid,
  input  wire mgw_pkg::mgw_rsp_t rsp,
  output logic                   rsp_ready
);
  ////////////////////////////////////////////////////////////
  initial begin
    req_valid = 1'b0;
    req = '1;
    rsp_ready = 1'b0;
  end
  // The released request bus carries the inverse of the last request so stale data never looks valid.
  task automatic xact(input mgw_req_t q, input int stall, output mgw_rsp_t r, output bit ok);
    ok = 1'b0;
    @(posedge clock);
    #1;
    req_valid = 1'b1;
    req = q;
    for (int i = 0; i < 20 && !ok; i++) begin
      ok = req_ready;
      @(posedge clock);
    end
    #1;
    req_valid = 1'b0;
    req = ~q;
    for (int i = 0; i < 20 && ok && !rsp_valid; i++) begin
      @(posedge clock);
      #1;
    end
    ok = ok && rsp_valid;
    repeat (stall) begin
      @(posedge clock);
      #1;
    end
    rsp_ready = 1'b1;
    @(posedge clock);
    r = rsp;
    #1;
    rsp_ready = 1'b0;
  endtask
endmodule // mgw_client
`default_nettype wire

//--- dv/test_mgw_gateway.sv
`timescale 1ns/1ps
`default_nettype none
module test_mgw_gateway;
  import mgw_pkg::*;
  logic        clock, rst, conn_req, conn_accept, conn_reject, req_valid, req_ready, rsp_valid, rsp_ready;
  logic        client_tsync, net_tsync, link, unstable, reprog, differs, panel_check, panel_rd_status;
  logic        resync_busy, resync_aborted;
  logic [31:0] auth_ip, conn_ip, net_time, time_now;
  logic [15:0] conn_port, panel_rd_data;
  logic [1:0]  panel_sel;
  logic [5:0]  panel_rd_idx;
  mgw_req_t    req;
  mgw_rsp_t    rsp;
  int          bad_count = 0;
  int          num_checks = 0;
  ////////////////////////////////////////////////////////////
  mgw_gateway #(.DAY_COUNT(50)) i_mgw_gateway (.clock(clock), .rst(rst), .auth_ip(auth_ip),
    .panel_node_0(8'h7F), .panel_node_1(8'h01), .panel_node_2(8'h02), .panel_node_3(8'hF7),
    .conn_req(conn_req), .conn_port(conn_port), .conn_ip(conn_ip), .conn_accept(conn_accept),
    .conn_reject(conn_reject), .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .rsp_ready(rsp_ready), .client_tsync(client_tsync), .net_tsync(net_tsync), .net_time(net_time),
    .time_now(time_now), .panel_link_up(link), .panel_unstable(unstable), .panel_reprog(reprog),
    .panel_db_differs(differs), .panel_rd_data(panel_rd_data), .panel_check(panel_check), .panel_sel(panel_sel),
    .panel_rd_status(panel_rd_status), .panel_rd_idx(panel_rd_idx), .resync_busy(resync_busy),
    .resync_aborted(resync_aborted));
  mgw_client i_mgw_client (.clock(clock), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .rsp_ready(rsp_ready));
  always #5 clock = ~clock;
  always @(posedge clock) panel_rd_data <= #1 {4'hA, 3'h0, panel_rd_status, panel_sel, panel_rd_idx};
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rsp(input mgw_rsp_t r, input logic [7:0] f, input logic [7:0] e);
    chk(r.func, f);
    chk(r.exc_code, e);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_busy(input logic exp, input int n);
    int i;
    for (i = 0; i < n && resync_busy !== exp; i++) step(1);
    chk(resync_busy, exp);
    if (resync_busy !== exp) finish_test();
  endtask
  task automatic rq(input logic [7:0] fn, un, input logic [15:0] ad, dt, input int st, output mgw_rsp_t r);
    bit ok;
    i_mgw_client.xact(mgw_req_t'({un, fn, ad, dt, TCP_PORT, 32'h00000000}), st, r, ok);
    chk(ok, 1'b1);
    if (!ok) finish_test();
  endtask
  task automatic exc1(input logic [7:0] fn, un, input logic [15:0] ad, dt, input logic [7:0] ex);
    mgw_rsp_t r;
    rq(fn, un, ad, dt, 0, r);
    chk_rsp(r, ex == 8'h00 ? fn : fn | EXC_FLAG, ex);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    mgw_rsp_t r;
    rq(FC_WR_SINGLE, 8'h7F, 16'h0005, 16'h1234, 0, r);
    chk_rsp(r, FC_WR_SINGLE, 8'h00);
    chk(r.data, 16'h1234);
    chk({r.unit_id, r.addr}, {8'h7F, 16'h0005});
    rq(FC_RD_HOLD, 8'h7F, 16'h0005, 16'h0001, 3, r);
    chk(r.data, 16'h1234);
    rq(FC_ENCAP, 8'h7F, 16'h0E00, 16'h0000, 0, r);
    chk(r.data, {MEI_DEV_ID, DEV_ID_OBJ});
    rq(FC_RD_INPUT, 8'hF7, 16'h003F, 16'h0001, 0, r);
    chk(r.data, 16'hA0FF);
    rq(FC_RD_HOLD, 8'hF7, 16'h003F, 16'h0001, 0, r);
    chk(r.data, 16'hA1FF);
    exc1(FC_RD_INPUT, 8'h7F, 16'h003F, 16'h0001, 8'h00);
    exc1(FC_WR_SINGLE, 8'hF7, 16'h0000, 16'h00AA, 8'h00);
    exc1(FC_RD_HOLD, 8'h01, 16'h003E, 16'h0002, 8'h00);
  endtask
  task automatic t_exc();
    mgw_rsp_t r;
    exc1(FC_RD_HOLD, 8'h00, 16'h0000, 16'h0001, EXC_ILL_DATA);
    exc1(FC_RD_HOLD, 8'hF8, 16'h0000, 16'h0001, EXC_ILL_DATA);
    exc1(FC_RD_HOLD, 8'h05, 16'h0000, 16'h0001, EXC_ILL_DATA);
    exc1(FC_RD_HOLD, 8'h7F, 16'h0000, 16'h0000, EXC_ILL_DATA);
    exc1(FC_RD_INPUT, 8'h7F, 16'h0000, 16'h007E, EXC_ILL_DATA);
    exc1(FC_RD_HOLD, 8'h7F, 16'h003F, 16'h0002, EXC_ILL_ADDR);
    exc1(FC_ENCAP, 8'h7F, 16'h0D00, 16'h0000, EXC_ILL_DATA);
    exc1(8'h10, 8'h7F, 16'h0005, 16'hBEEF, EXC_ILL_FUNC);
    rq(FC_RD_HOLD, 8'h7F, 16'h0005, 16'h0001, 0, r);
    chk(r.data, 16'h1234);
  endtask
  task automatic t_conn();
    logic [31:0] ips[4] = '{32'h0A000001, 32'h0A000001, 32'h0A000002, 32'h0A000002};
    logic [31:0] auth[4] = '{32'h0A000001, 32'h0A000001, 32'h0A000001, IP_ANY};
    logic [15:0] ports[4] = '{TCP_PORT, 16'h01F5, TCP_PORT, TCP_PORT};
    logic        acc[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      {conn_ip, auth_ip, conn_port, conn_req} = {ips[i], auth[i], ports[i], 1'b1};
      step(1);
      chk({conn_accept, conn_reject}, {acc[i], ~acc[i]});
    end
    conn_req = 1'b0;
  endtask
  task automatic t_time();
    {net_time, net_tsync} = {32'h12345678, 1'b1};
    step(1);
    {net_time, net_tsync, client_tsync} = {32'hDEAD0000, 1'b0, 1'b1};
    chk(time_now, 32'h12345678);
    step(1);
    client_tsync = 1'b0;
    step(1);
    chk(time_now, 32'h12345678);
  endtask
  task automatic t_resync();
    int i;
    for (i = 0; i < 60 && panel_check !== 1'b1; i++) step(1);
    chk(panel_check, 1'b1);
    step(3);
    chk(resync_busy, 1'b0);
    differs = 1'b1;
    wait_busy(1'b1, 120);
    differs = 1'b0;
    wait_busy(1'b0, 600);
    reprog = 1'b1;
    step(1);
    reprog = 1'b0;
    wait_busy(1'b1, 5);
    step(10);
    unstable = 1'b1;
    for (i = 0; i < 5 && resync_aborted !== 1'b1; i++) step(1);
    chk(resync_aborted, 1'b1);
    step(2);
    unstable = 1'b0;
    chk(resync_busy, 1'b0);
    wait_busy(1'b0, 600);
    link = 1'b0;
    step(3);
    link = 1'b1;
    wait_busy(1'b1, 5);
    wait_busy(1'b0, 600);
  endtask
  initial begin
    {clock, rst, conn_req, client_tsync, net_tsync, unstable, reprog, differs, link} = 9'h081;
    {auth_ip, conn_ip, net_time, conn_port} = '0;
    step(5);
    rst = 1'b0;
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 600);
    t_regs();
    t_exc();
    t_conn();
    t_time();
    t_resync();
    finish_test();
  end
endmodule // test_mgw_gateway
`default_nettype wire
